//--- tadc_pkg.sv
package tadc_pkg;
  // Core clock rate in MHz; every time below is turned into cycles of it.
  localparam int CLOCK_MHZ = 25;
  // Result, control byte and channel field layout.
  localparam int RESULT_BITS = 10;
  localparam int SHORT_BITS  = 8;
  localparam int CTRL_BITS   = 8;
  localparam int CHAN_BITS   = 3;
  localparam int CHAN_MSB    = 7;
  localparam int CHAN_LSB    = 5;
  localparam logic [2:0] CHAN_TEMP    = 3'h0;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  // Conversion times in microseconds and their cycle counts.
  localparam int CONV_ANALOG_US     = 9;
  localparam int CONV_TEMP_US       = 27;
  localparam int CONV_ANALOG_CYCLES = CONV_ANALOG_US * CLOCK_MHZ;
  localparam int CONV_TEMP_CYCLES   = CONV_TEMP_US * CLOCK_MHZ;
  localparam int COUNT_BITS         = 10;
  // Host timing: start pulse, power-up hold and quiet time, rounded up.
  localparam int START_LOW_NS      = 200;
  localparam int START_LOW_CYCLES  = (START_LOW_NS * CLOCK_MHZ + 999) / 1000;
  localparam int POWER_UP_NS       = 2000;
  localparam int POWER_UP_CYCLES   = (POWER_UP_NS * CLOCK_MHZ + 999) / 1000;
  localparam int QUIET_NS          = 100;
  localparam int QUIET_CYCLES      = (QUIET_NS * CLOCK_MHZ + 999) / 1000;
  localparam int SCLK_HALF_CYCLES  = 2;
  localparam int WAIT_BITS         = 6;
  localparam int EDGE_BITS         = 4;
  // Host sequencer states.
  typedef enum {H_IDLE, H_START, H_WAIT_END, H_WR_PRE, H_SETUP, H_CLOCK, H_QUIET} host_state_t;
endpackage

//--- tadc_link_if.sv
`timescale 1ns/100ps
// Link between the host and the converter; the shared data wire is resolved here.
interface tadc_link_if #(
  parameter bit SHARED_PIN = 1'b0
);
  logic serial_clock;       // Serial clock, made by the host, idles low.
  logic conversion_start_n; // Conversion start, active low.
  logic busy;               // High while a conversion runs.
  logic rd_wr;              // High for a read, low for a write.
  logic cs_n;               // Chip select of the separate-pin variant.
  logic host_data;          // Host data out.
  logic host_data_oe;       // Host drives the data wire.
  logic dev_data;           // Converter data out.
  logic dev_data_oe;        // Converter drives the data wire.
  logic shared_line;        // Level of the single shared wire.
  logic dev_sees;           // Data level at the converter input.
  logic host_sees;          // Data level at the host input.

  // An undriven wire floats high through a pull-up.
  assign shared_line = dev_data_oe ? dev_data : (host_data_oe ? host_data : 1'b1);
  assign dev_sees    = SHARED_PIN ? shared_line : host_data;
  assign host_sees   = SHARED_PIN ? shared_line : (dev_data_oe ? dev_data : 1'b1);

  modport device (
    input  serial_clock, conversion_start_n, rd_wr, cs_n, dev_sees,
    output busy, dev_data, dev_data_oe
  );
  modport host (
    output serial_clock, conversion_start_n, rd_wr, cs_n, host_data, host_data_oe,
    input  busy, host_sees
  );
endinterface

//--- conv_timer.sv
`timescale 1ns/100ps
// Times one conversion on the internal clock and drives the busy flag.
module conv_timer (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic start,
  input  wire logic temp_channel,
  output logic      busy,
  output logic      finishing
);
  import tadc_pkg::*;

  logic [COUNT_BITS-1:0] remaining; // Cycles left after the current one.

  // Busy rises on the edge that takes a start and stays high for the full count.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy      <= 1'b0;
      remaining <= '0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      // The temperature channel needs three times as long.
      if (temp_channel) begin
        remaining <= COUNT_BITS'(CONV_TEMP_CYCLES - 1);
      end else begin
        remaining <= COUNT_BITS'(CONV_ANALOG_CYCLES - 1);
      end
    end else if (busy) begin
      if (remaining == '0) begin
        busy <= 1'b0;
      end else begin
        remaining <= remaining - 1'b1;
      end
    end
  end

  // Marks the last busy cycle so that the result lands on the edge busy falls.
  assign finishing = busy && (remaining == '0);
endmodule

//--- tadc_device.sv
`timescale 1ns/100ps
module tadc_device #(
  parameter bit SHARED_PIN = 1'b0
) (
  input  wire logic                            clock,
  input  wire logic                            resetn,
  tadc_link_if.device                          link,
  input  wire logic [tadc_pkg::RESULT_BITS-1:0] sample_code,
  output logic [tadc_pkg::CHAN_BITS-1:0]       channel_select,
  output logic                                 track_hold,
  output logic                                 power_on,
  output logic [tadc_pkg::CTRL_BITS-1:0]       control_byte,
  output logic [tadc_pkg::RESULT_BITS-1:0]     result
);
  import tadc_pkg::*;

  // Conversion side, on the internal clock.
  logic [2:0]             start_sync;  // Three-stage synchroniser for the start pin.
  logic                   start_level; // Filtered start level, high when idle.
  logic                   start_agree; // Second and third stage agree.
  logic                   start_fall;  // Filtered start level goes low.
  logic                   start_rise;  // Filtered start level goes high.
  logic                   busy;        // Conversion in progress.
  logic                   finishing;   // Last cycle of the conversion.
  logic                   powered_down; // Converter sleeps after a mode two conversion.
  logic [2:0]             ctrl_sync;   // Synchroniser for the control toggle.
  logic                   ctrl_seen;   // Toggle value already taken over.

  // Link side, on the serial clock.
  logic                   read_clear_n;  // Holds the read pointer while not reading.
  logic                   write_clear_n; // Holds the write counter while not writing.
  logic                   port_enabled;  // Chip select or the shared variant.
  logic [3:0]             rd_index;      // Result bit now on the pin.
  logic                   lead_in_done;  // Shared pin: first falling edge passed.
  logic [3:0]             bit_pos;       // Result bit position shown on the pin.
  logic [3:0]             wr_count;      // Control bits taken so far.
  logic [CTRL_BITS-1:0]   wr_shift;      // Control bits being gathered.
  logic [CTRL_BITS-1:0]   ctrl_word;     // Last complete control byte.
  logic                   ctrl_toggle;   // Flips once per complete control byte.

  // The start pin comes from another domain, so it passes three flip-flops.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      start_sync <= 3'h7;
    end else begin
      start_sync <= {start_sync[1:0], link.conversion_start_n};
    end
  end

  assign start_agree = (start_sync[1] == start_sync[2]);
  assign start_fall  = start_agree && !start_sync[2] && start_level;
  assign start_rise  = start_agree && start_sync[2] && !start_level;

  // A level change counts only once the last two stages agree.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      start_level <= 1'b1;
    end else if (start_agree) begin
      start_level <= start_sync[2];
    end
  end

  // The internal clock times the conversion, not the serial clock.
  conv_timer u_timer (
    .clock        (clock),
    .resetn       (resetn),
    .start        (start_fall),
    .temp_channel (channel_select == CHAN_TEMP),
    .busy         (busy),
    .finishing    (finishing)
  );

  assign link.busy  = busy;
  // Track/hold sits in hold for the whole conversion.
  assign track_hold = busy;

  // The result changes only at the end of a conversion, so reads stay stable.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result <= RESULT_RESET;
    end else if (finishing) begin
      result <= sample_code;
    end
  end

  // Power control: sleep when start is still low as busy falls.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      powered_down <= 1'b0;
    end else begin
      if (finishing && !start_level) begin
        powered_down <= 1'b1;
      end
      // Waking wins when both happen together, so a rising start is never lost.
      if (start_rise) begin
        powered_down <= 1'b0;
      end
    end
  end

  assign power_on = !powered_down;

  // The control toggle crosses into the internal clock domain.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_sync <= 3'h0;
    end else begin
      ctrl_sync <= {ctrl_sync[1:0], ctrl_toggle};
    end
  end

  // A new control byte is taken once the toggle has settled; the word is
  // stable by then because the host must pulse the select before writing again.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_seen      <= 1'b0;
      channel_select <= CHAN_TEMP;
      control_byte   <= CTRL_RESET;
    end else if ((ctrl_sync[1] == ctrl_sync[2]) && (ctrl_sync[2] != ctrl_seen)) begin
      ctrl_seen      <= ctrl_sync[2];
      channel_select <= ctrl_word[CHAN_MSB:CHAN_LSB];
      control_byte   <= ctrl_word;
    end
  end

  // The serial clock only runs during transfers, so the select line clears
  // the link counters asynchronously instead of waiting for an edge.
  assign read_clear_n  = resetn & link.rd_wr;
  assign write_clear_n = resetn & ~link.rd_wr;
  assign port_enabled  = SHARED_PIN || !link.cs_n;

  // Read pointer: the MSB shows as soon as the select rises, then one bit per falling edge.
  always_ff @(negedge link.serial_clock or negedge read_clear_n) begin
    if (!read_clear_n) begin
      rd_index     <= 4'h0;
      lead_in_done <= 1'b0;
    end else if (!port_enabled) begin
      rd_index <= rd_index;
    end else if (SHARED_PIN && !lead_in_done) begin
      // The shared pin skips the first falling edge as a turnaround.
      lead_in_done <= 1'b1;
    end else if (rd_index != 4'(RESULT_BITS)) begin
      rd_index <= rd_index + 1'b1;
    end
  end

  assign bit_pos = 4'(RESULT_BITS - 1) - rd_index;

  // Past the tenth bit the pin reads low; a short read simply stops early.
  always_comb begin
    if (rd_index < 4'(RESULT_BITS)) begin
      link.dev_data = result[bit_pos];
    end else begin
      link.dev_data = 1'b0;
    end
  end

  // The result word is read across domains without a handshake; it is
  // safe only because it never changes while busy is low.
  always_comb begin
    if (SHARED_PIN) begin
      link.dev_data_oe = resetn && link.rd_wr;
    end else begin
      link.dev_data_oe = resetn && link.rd_wr && !link.cs_n;
    end
  end

  // Write counter: the first eight rising edges load bits, later ones are ignored.
  always_ff @(posedge link.serial_clock or negedge write_clear_n) begin
    if (!write_clear_n) begin
      wr_count <= 4'h0;
      wr_shift <= CTRL_RESET;
    end else if (port_enabled && (wr_count != 4'(CTRL_BITS))) begin
      wr_count <= wr_count + 1'b1;
      wr_shift <= {wr_shift[CTRL_BITS-2:0], link.dev_sees};
    end
  end

  // The finished byte and its toggle survive the select going high again.
  always_ff @(posedge link.serial_clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_word   <= CTRL_RESET;
      ctrl_toggle <= 1'b0;
    end else if (!link.rd_wr && port_enabled && (wr_count == 4'(CTRL_BITS - 1))) begin
      ctrl_word   <= {wr_shift[CTRL_BITS-2:0], link.dev_sees};
      ctrl_toggle <= ~ctrl_toggle;
    end
  end
endmodule

//--- tadc_host.sv
`timescale 1ns/100ps
// Host end: starts conversions, clocks the serial port and reads or writes.
module tadc_host #(
  parameter bit SHARED_PIN = 1'b0
) (
  input  wire logic                            clock,
  input  wire logic                            resetn,
  tadc_link_if.host                            link,
  input  wire logic                            convert_req,
  input  wire logic                            auto_power_down,
  input  wire logic                            read_req,
  input  wire logic                            read_short,
  input  wire logic                            write_req,
  input  wire logic [tadc_pkg::CTRL_BITS-1:0]  write_byte,
  output logic                                 ready,
  output logic                                 busy_seen,
  output logic [tadc_pkg::RESULT_BITS-1:0]     result,
  output logic                                 result_valid
);
  import tadc_pkg::*;

  host_state_t            state;      // Sequencer state.
  logic [WAIT_BITS-1:0]   wait_cnt;   // Cycles left in a timed step.
  logic [EDGE_BITS-1:0]   edge_cnt;   // Rising edges made so far.
  logic [EDGE_BITS-1:0]   edge_total; // Rising edges the transfer needs.
  logic                   reading;    // Transfer is a read.
  logic                   short_read; // Only eight bits are wanted.
  logic                   mode_two;   // Start stays low until busy falls.
  logic                   saw_busy;   // Busy has risen for this conversion.
  logic                   sclk;       // Serial clock, idles low.
  logic                   start_n;    // Conversion start pin.
  logic                   rd_wr;      // Read or write select pin.
  logic                   cs_n;       // Chip select pin.
  logic                   tx_oe;      // Host drives data.
  logic [CTRL_BITS-1:0]   tx_shift;   // Control bits, MSB on the pin.
  logic [RESULT_BITS-1:0] rx_shift;   // Result bits gathered MSB first.
  logic [2:0]             busy_sync;  // Synchroniser for the busy pin.

  assign link.serial_clock       = sclk;
  assign link.conversion_start_n = start_n;
  assign link.rd_wr              = rd_wr;
  assign link.cs_n               = cs_n;
  assign link.host_data          = tx_shift[CTRL_BITS-1];
  assign link.host_data_oe       = tx_oe;
  assign ready                   = (state == H_IDLE);

  // Busy comes from the converter's clock, so it passes three flip-flops.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_sync <= 3'h0;
      busy_seen <= 1'b0;
    end else begin
      busy_sync <= {busy_sync[1:0], link.busy};
      if (busy_sync[1] == busy_sync[2]) begin
        busy_seen <= busy_sync[2];
      end
    end
  end

  // Sequencer; it also makes the serial clock by dividing its own clock.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= H_IDLE;
      wait_cnt <= '0;
      edge_cnt <= '0;
      edge_total <= '0;
      reading <= 1'b0;
      short_read <= 1'b0;
      mode_two <= 1'b0;
      saw_busy <= 1'b0;
      sclk <= 1'b0;
      start_n <= 1'b1;
      rd_wr <= 1'b0;
      cs_n <= 1'b1;
      tx_oe <= 1'b0;
      tx_shift <= CTRL_RESET;
      rx_shift <= RESULT_RESET;
      result <= RESULT_RESET;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      unique case (state)
        H_IDLE: begin
          edge_cnt <= '0;
          if (convert_req) begin
            start_n  <= 1'b0;
            mode_two <= auto_power_down;
            saw_busy <= 1'b0;
            // Mode two holds start low at least for the power-up time.
            wait_cnt <= auto_power_down ? WAIT_BITS'(POWER_UP_CYCLES - 1)
                                        : WAIT_BITS'(START_LOW_CYCLES - 1);
            state    <= H_START;
          end else if (read_req) begin
            // Select was low while idle, so raising it is a fresh read.
            rd_wr      <= 1'b1;
            cs_n       <= 1'b0;
            reading    <= 1'b1;
            short_read <= read_short;
            edge_total <= EDGE_BITS'((read_short ? SHORT_BITS : RESULT_BITS) + (SHARED_PIN ? 1 : 0));
            wait_cnt   <= WAIT_BITS'(SCLK_HALF_CYCLES - 1);
            state      <= H_SETUP;
          end else if (write_req) begin
            // A high pulse on the select lets the converter see a new write.
            rd_wr      <= 1'b1;
            reading    <= 1'b0;
            tx_shift   <= write_byte;
            edge_total <= EDGE_BITS'(CTRL_BITS);
            wait_cnt   <= WAIT_BITS'(SCLK_HALF_CYCLES - 1);
            state      <= H_WR_PRE;
          end
        end
        H_START: begin
          if (wait_cnt == '0) begin
            // Mode one raises start long before busy can fall.
            if (!mode_two) begin
              start_n <= 1'b1;
            end
            state <= H_WAIT_END;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        H_WAIT_END: begin
          if (busy_seen) begin
            saw_busy <= 1'b1;
          end else if (saw_busy) begin
            start_n <= 1'b1;
            state   <= H_IDLE;
          end
        end
        H_WR_PRE: begin
          if (wait_cnt == '0) begin
            rd_wr    <= 1'b0;
            cs_n     <= 1'b0;
            tx_oe    <= 1'b1;
            wait_cnt <= WAIT_BITS'(SCLK_HALF_CYCLES - 1);
            state    <= H_SETUP;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        H_SETUP: begin
          if (wait_cnt == '0) begin
            wait_cnt <= WAIT_BITS'(SCLK_HALF_CYCLES - 1);
            state    <= H_CLOCK;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        H_CLOCK: begin
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
          end else begin
            wait_cnt <= WAIT_BITS'(SCLK_HALF_CYCLES - 1);
            sclk     <= ~sclk;
            if (!sclk) begin
              // Rising edge: the shared pin repeats its MSB on the first one.
              edge_cnt <= edge_cnt + 1'b1;
              if (reading && !(SHARED_PIN && edge_cnt == '0)) begin
                rx_shift <= {rx_shift[RESULT_BITS-2:0], link.host_sees};
              end
            end else if (edge_cnt == edge_total) begin
              // Last falling edge: close the transfer; in a read the select stays high till now.
              rd_wr    <= 1'b0;
              cs_n     <= 1'b1;
              tx_oe    <= 1'b0;
              wait_cnt <= WAIT_BITS'(QUIET_CYCLES - 1);
              state    <= H_QUIET;
              if (reading) begin
                result       <= short_read ? {rx_shift[SHORT_BITS-1:0], 2'b00} : rx_shift;
                result_valid <= 1'b1;
              end
            end else if (!reading) begin
              tx_shift <= {tx_shift[CTRL_BITS-2:0], 1'b0};
            end
          end
        end
        H_QUIET: begin
          // Quiet time lets the track/hold settle before the next start.
          if (wait_cnt == '0) begin
            state <= H_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
      endcase
    end
  end
endmodule

//--- tadc_link_asserts.sv
`timescale 1ns/100ps
// Watches the host to converter link in both clock domains.
module tadc_link_asserts
  import tadc_pkg::*;
(
  input wire logic clock,
  input wire logic link_clock,
  input wire logic resetn,
  input wire logic serial_clock,
  input wire logic conversion_start_n,
  input wire logic busy,
  input wire logic rd_wr,
  input wire logic cs_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe
);
  logic [9:0] busy_len; // Link cycles busy has stayed high.
  logic [3:0] rise_cnt; // Serial clock rises seen in this transfer.
  logic       sclk_d;   // Serial clock one cycle ago.
  // Busy time restarts at zero for every conversion.
  always_ff @(posedge link_clock or negedge resetn) begin
    if (!resetn)
      busy_len <= 10'h000;
    else
      busy_len <= busy ? busy_len + 10'h001 : 10'h000;
  end
  // Rises are counted only while selected, so a stray clock cannot leak into the next transfer.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_d   <= 1'b0;
      rise_cnt <= 4'h0;
    end else begin
      sclk_d   <= serial_clock;
      rise_cnt <= cs_n ? 4'h0 : rise_cnt + {3'h0, serial_clock & ~sclk_d};
    end
  end
  busy_len_a: assert property (@(posedge link_clock) disable iff (!resetn)
    $fell(busy) |-> (busy_len == CONV_ANALOG_CYCLES || busy_len == CONV_TEMP_CYCLES)) else $error("busy length wrong");
  start_busy_a: assert property (@(posedge link_clock) disable iff (!resetn)
    $fell(conversion_start_n) && !busy |-> ##[1:8] busy) else $error("busy did not rise");
  out_float_a: assert property (@(posedge clock) disable iff (!resetn)
    (cs_n || !rd_wr) |-> !dev_data_oe) else $error("data out driven when deselected");
  out_drive_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(rd_wr) && !cs_n |-> ##[0:2] dev_data_oe) else $error("data out not driven in read");
  sclk_idle_a: assert property (@(posedge clock) disable iff (!resetn)
    cs_n |-> !serial_clock) else $error("serial clock outside transfer");
  xfer_len_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(cs_n) |-> (rise_cnt == 4'h8 || rise_cnt == 4'hA)) else $error("transfer length wrong");
  write_len_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(cs_n) && $past(host_data_oe) |-> rise_cnt == 4'h8) else $error("write length wrong");
  host_drive_a: assert property (@(posedge clock) disable iff (!resetn)
    host_data_oe |-> !rd_wr && !cs_n) else $error("host drives data outside write");
  cover property (@(posedge link_clock) disable iff (!resetn) $fell(busy) && busy_len == CONV_TEMP_CYCLES);
  cover property (@(posedge link_clock) disable iff (!resetn) $fell(busy) && busy_len == CONV_ANALOG_CYCLES);
  cover property (@(posedge clock) disable iff (!resetn) $rose(cs_n) && rise_cnt == 4'h8);
endmodule

//--- temp_adc_conversion_serial_port_bench.sv
`timescale 1ns/100ps
// Joins host and converter and compares every result with a bench model.
module temp_adc_conversion_serial_port_bench;
  import tadc_pkg::*;
  logic       clock, link_clock, resetn;                           // Clocks and shared reset.
  logic       convert_req, auto_power_down, read_req, read_short, write_req;
  logic [7:0] write_byte;                                          // Control byte to send.
  logic [9:0] sample_code, model_res;                              // Analog code and the model's result.
  logic [2:0] model_ch;                                            // Channel the model expects.
  logic       ready, power_on, down_seen, hold, res_vld;
  logic [9:0] h_res, d_res;
  logic [2:0] chan;
  logic [7:0] ctrl;
  int         error_cnt, tests_run, cyc, busy_len, last_len, vld_cnt;
  tadc_link_if #(.SHARED_PIN(1'b0)) link ();
  tadc_device #(.SHARED_PIN(1'b0)) i_tadc_device (.clock(link_clock), .resetn(resetn), .link(link),
    .sample_code(sample_code), .channel_select(chan), .track_hold(hold), .power_on(power_on),
    .control_byte(ctrl), .result(d_res));
  tadc_host #(.SHARED_PIN(1'b0)) i_tadc_host (.clock(clock), .resetn(resetn), .link(link),
    .convert_req(convert_req), .auto_power_down(auto_power_down), .read_req(read_req),
    .read_short(read_short), .write_req(write_req), .write_byte(write_byte), .ready(ready),
    .busy_seen(), .result(h_res), .result_valid(res_vld));
  tadc_link_asserts i_tadc_link_asserts (.clock(clock), .link_clock(link_clock), .resetn(resetn),
    .serial_clock(link.serial_clock), .conversion_start_n(link.conversion_start_n), .busy(link.busy),
    .rd_wr(link.rd_wr), .cs_n(link.cs_n), .host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe));
  // Both clocks run at 40 ns; the converter's clock is offset so the two never line up.
  // The conversion counts assume a 25 MHz converter clock, so a slower one would stretch busy.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #13;
    forever #20 link_clock = ~link_clock;
  end
  // Measures each busy pulse in converter cycles, notes any power-down and checks the hold.
  always @(posedge link_clock) begin
    check({9'h0, hold}, {9'h0, link.busy});
    if (link.busy === 1'b1)
      busy_len++;
    else if (busy_len != 0) begin
      last_len = busy_len;
      busy_len = 0;
    end
    if (power_on === 1'b0)
      down_seen = 1'b1;
  end
  // Cuts a hang short; the longest conversion is about 700 host cycles.
  // Also counts the one-cycle result strobes, which a polling task would miss.
  always @(posedge clock) begin
    cyc++;
    if (res_vld === 1'b1)
      vld_cnt++;
    if (cyc == 40000) begin
      error_cnt++;
      $display("Error at %0t: cycles %h expected below %h", $time, cyc, 40000);
      give_verdict();
    end
  end
  task automatic check(input logic [9:0] got, input logic [9:0] want);
    tests_run++;
    if (got !== want) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // Issues one request (0 convert, 1 read, 2 write) and waits for idle.
  task automatic op(input int kind);
    int n;
    @(posedge clock);
    convert_req <= (kind == 0);
    read_req    <= (kind == 1);
    write_req   <= (kind == 2);
    @(posedge clock);
    {convert_req, read_req, write_req} <= 3'h0;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (ready !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      error_cnt++;
      $display("Error at %0t: ready %h expected %h", $time, ready, 1'b1);
    end
  endtask
  task automatic convert(input logic m2);
    @(posedge clock);
    auto_power_down <= m2;
    sample_code     <= 10'($urandom);
    down_seen = 1'b0;
    op(0);
    repeat (20) @(posedge clock);
    model_res = sample_code;
    check(d_res, model_res);
    check(10'(last_len), model_ch == CHAN_TEMP ? 10'(CONV_TEMP_CYCLES) : 10'(CONV_ANALOG_CYCLES));
    check({9'h0, down_seen}, {9'h0, m2});
    check({9'h0, power_on}, 10'h001);
    $display("conversion test done");
  endtask
  // A new analog code is applied first: the stored result must not follow it.
  task automatic rd(input logic short_rd);
    int v0;
    @(posedge clock);
    v0 = vld_cnt;
    read_short  <= short_rd;
    sample_code <= 10'($urandom);
    op(1);
    check(h_res, short_rd ? {model_res[9:2], 2'b00} : model_res);
    check(10'(vld_cnt - v0), 10'h001);
    $display("read test done");
  endtask
  task automatic wr(input logic [7:0] b);
    @(posedge clock);
    write_byte <= b;
    op(2);
    model_ch = b[CHAN_MSB:CHAN_LSB];
    repeat (8) @(posedge link_clock);
    #1;
    check({2'h0, ctrl}, {2'h0, b});
    check({7'h0, chan}, {7'h0, model_ch});
    $display("write test done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Reset checks, then conversions in both modes, back-to-back reads and writes.
  initial begin
    {resetn, convert_req, auto_power_down, read_req, read_short, write_req} = 6'h00;
    {write_byte, sample_code} = 18'h00000;
    void'($urandom(32'h3C11));
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    #1;
    check(d_res, RESULT_RESET);
    check({7'h0, chan}, {7'h0, CHAN_TEMP});
    check({2'h0, ctrl}, {2'h0, CTRL_RESET});
    check({9'h0, power_on}, 10'h001);
    $display("reset test done");
    model_ch = CHAN_TEMP;
    convert(1'b0);
    rd(1'b0);
    rd(1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(8'($urandom));
      wr(8'($urandom));
      convert(i[0]);
      rd(i[1]);
    end
    give_verdict();
  end
endmodule
